// *** core/dmr_params.svh ***
`ifndef DMR_PARAMS_SVH
`define DMR_PARAMS_SVH

// Register select codes taken from bank group 0 and the two bank address bits.
`define DMR_SEL_MR0 3'h0
`define DMR_SEL_MR1 3'h1
`define DMR_SEL_MR2 3'h2
`define DMR_SEL_MR5 3'h5
`define DMR_SEL_IGNORE 3'h7
`define DMR_MR_COUNT 7
`define DMR_MR_WIDTH 18
`define DMR_MR_RESET 18'h00000

// Command pin positions on the address bus (row, column and write strobes).
`define DMR_A_ROW 16
`define DMR_A_COL 15
`define DMR_A_WEN 14

// Field positions of the first mode register.
`define DMR_MR1_DRV 2:1
`define DMR_MR1_AL 4:3
`define DMR_MR1_WLEV 7
`define DMR_MR1_NOM 10:8
`define DMR_MR1_TERMINATION_STROBE_FUNCTION 11
`define DMR_MR1_QOFF 12

// Field positions of the second mode register.
`define DMR_MR2_CWL 5:3
`define DMR_MR2_SRR 7:6
`define DMR_MR2_WTERM 11:9
`define DMR_MR2_CRC 12

// Field positions of the fifth mode register.
`define DMR_MR5_PARK 8:6
`define DMR_MR5_DM 10
`define DMR_MR5_WDBI 11
`define DMR_MR5_RDBI 12

// Read latency field of the zeroth mode register and its base value.
`define DMR_MR0_CL 6:3
`define DMR_CL_BASE 6'h09

// Additive latency codes and their offsets from the read latency.
`define DMR_AL_CL1 2'h1
`define DMR_AL_CL2 2'h2
`define DMR_AL_SUB1 6'h01
`define DMR_AL_SUB2 6'h02
`define DMR_AL_ZERO 6'h00

// Write latency codes and cycle counts.
`define DMR_CWL_C0 5'h09
`define DMR_CWL_C1 5'h0A
`define DMR_CWL_C2 5'h0B
`define DMR_CWL_C3 5'h0C
`define DMR_CWL_C4 5'h0E
`define DMR_CWL_C5 5'h10
`define DMR_CWL_C6 5'h12

// Termination codes: zero is off, codes from five upward are reserved.
`define DMR_TERM_OFF 3'h0
`define DMR_WT_RSV_LO 3'h5

// Burst windows in link clock cycles: 8 or 10 unit intervals, double rate.
`define DMR_BURST_BL8 3'h4
`define DMR_BURST_CRC 3'h5
`define DMR_WIN_STEP 3'h1
`define DMR_WIN_IDLE 3'h0

// Depth of the command delay lines; covers the longest total latency.
`define DMR_PIPE_DEPTH 48

`endif

// *** core/dmr_pkg.sv ***
`include "dmr_params.svh"

package dmr_pkg;

	typedef struct packed {
		logic [1:0] drive_impedance;
		logic [2:0] nominal_termination;
		logic [2:0] write_termination;
		logic [2:0] park_termination;
		logic output_disable;
		logic write_leveling;
		logic termination_strobe_function;
		logic write_byte_mask;
		logic write_bus_inversion;
		logic read_bus_inversion;
		logic write_crc;
		logic [1:0] self_refresh_range;
		logic [4:0] cas_write_delay;
		logic [5:0] additive_latency;
		logic [5:0] total_read_delay;
		logic [5:0] total_write_delay;
	} dmr_cfg_s;

	typedef enum logic [1:0] {
		DMR_HS_IDLE = 2'b01,
		DMR_HS_BUSY = 2'b10
	} dmr_hs_e;

	typedef struct packed {
		logic [`DMR_MR_COUNT-1:0][`DMR_MR_WIDTH-1:0] mr;
		logic [`DMR_PIPE_DEPTH-1:0] rd_pipe;
		logic [`DMR_PIPE_DEPTH-1:0] wr_pipe;
		logic [2:0] rd_win;
		logic [2:0] wr_win;
		logic rd_issue;
		logic wr_issue;
		logic rd_due;
		logic wr_due;
		logic wr_ten;
		logic dq_drive;
		logic lvl_fb;
		logic [2:0] dq_term;
		logic [2:0] strobe_term;
		logic [2:0] termination_strobe_function_term;
		dmr_hs_e hs;
		logic req_tgl;
		logic dirty;
		dmr_cfg_s hold;
	} dmr_link_s;

	typedef struct packed {
		dmr_cfg_s cfg;
		logic req_seen;
	} dmr_main_s;

endpackage : dmr_pkg

// *** core/dmr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second.
module dmr_sync #(
	parameter int W = 1
) (
	// Clock of the receiving domain
	input wire logic clk_i,
	// Data from the foreign domain
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dmr_sync_s;

	dmr_sync_s st_reg;
	dmr_sync_s st_next;

	always_comb begin
		st_next.s1 = d_i;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_i) begin
		st_reg <= st_next;
	end

	assign q_o = st_reg.s2;
endmodule // dmr_sync

`default_nettype wire

// *** core/dmr_mode_config.sv ***
// What this block does
// RULE1: Driver impedance from first register bits 2,1.
// RULE2: Write termination applies during writes, nominal regardless; here only with control pin high and leveling off.
// RULE3: Park termination applies while control pin low.
// RULE4: Read/write accepted anytime, issued after additive latency.
// RULE5: Read data due at additive plus read latency.
// RULE6: Write data due at additive plus write latency.
// RULE7: Write leveling returns sampled clock level as feedback.
// RULE8: Output disable bit 12 disconnects data and strobes.
// RULE9: Controller enables termination strobe on by-8 only.
// RULE10: Primary strobes get the termination strobe termination.
// RULE11: Termination strobe disables mask and both inversions.
// RULE12: Mask and write inversion never both; read independent.
// RULE13: Select 000-110 picks register, 111 is ignored.
// RULE14: Controller never writes reserved field codes.
// RULE15: Controller drives reserved address bits to zero.
// RULE16: Write latency from second register bits 5:3.
// RULE17: Write termination from second register bits 11:9.
// RULE18: Write CRC stretches write burst to ten intervals.
// RULE19: Write termination codes off,120,240,high-Z,80; rest reserved.
// RULE20: Write latency codes give 9,10,11,12,14,16,18.
// RULE21: Bit 12 enables CRC; bits 7:6 pick refresh range.
`timescale 1ns/1ps
`default_nettype none

`include "dmr_params.svh"

module dmr_mode_config (
	// Core clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Link clock and command pins from the controller
	input wire logic link_clk_i,
	input wire logic cs_n_i,
	input wire logic act_n_i,
	input wire logic [1:0] bg_i,
	input wire logic [1:0] ba_i,
	input wire logic [`DMR_MR_WIDTH-1:0] addr_i,
	input wire logic termination_control_pin_i,
	// Clock level caught by the strobe edge during write leveling
	input wire logic level_sample_i,
	// Link-side results
	output logic read_issue_o,
	output logic write_issue_o,
	output logic read_data_due_o,
	output logic write_data_due_o,
	output logic write_burst_ten_o,
	output logic dq_drive_en_o,
	output logic level_feedback_o,
	output logic [2:0] dq_termination_o,
	output logic [2:0] strobe_termination_o,
	output logic [2:0] termination_strobe_function_termination_o,
	// Settings seen by the core
	output logic [1:0] drive_impedance_o,
	output logic [2:0] nominal_termination_o,
	output logic [2:0] write_termination_o,
	output logic [2:0] park_termination_o,
	output logic output_disable_o,
	output logic write_leveling_o,
	output logic termination_strobe_function_o,
	output logic write_byte_mask_o,
	output logic write_bus_inversion_o,
	output logic read_bus_inversion_o,
	output logic write_crc_o,
	output logic [1:0] self_refresh_range_o,
	output logic [4:0] cas_write_delay_o,
	output logic [5:0] additive_latency_o,
	output logic [5:0] total_read_delay_o,
	output logic [5:0] total_write_delay_o
);

	function automatic logic [4:0] dmr_cwl(input logic [2:0] code);
		logic [4:0] cyc;
		case (code) // RULE20
			3'h0: cyc = `DMR_CWL_C0;
			3'h1: cyc = `DMR_CWL_C1;
			3'h2: cyc = `DMR_CWL_C2;
			3'h3: cyc = `DMR_CWL_C3;
			3'h4: cyc = `DMR_CWL_C4;
			3'h5: cyc = `DMR_CWL_C5;
			3'h6: cyc = `DMR_CWL_C6;
			default: cyc = `DMR_CWL_C0;
		endcase
		return cyc;
	endfunction

	function automatic dmr_pkg::dmr_cfg_s dmr_decode(
		input logic [`DMR_MR_COUNT-1:0][`DMR_MR_WIDTH-1:0] mr
	);
		dmr_pkg::dmr_cfg_s c;
		logic [5:0] cl;
		logic [2:0] wt;
		logic [17:0] m0;
		logic [17:0] m1;
		logic [17:0] m2;
		logic [17:0] m5;
		m0 = mr[`DMR_SEL_MR0];
		m1 = mr[`DMR_SEL_MR1];
		m2 = mr[`DMR_SEL_MR2];
		m5 = mr[`DMR_SEL_MR5];
		cl = 6'(m0[`DMR_MR0_CL]) + `DMR_CL_BASE;
		c.drive_impedance = m1[`DMR_MR1_DRV]; // RULE1
		c.nominal_termination = m1[`DMR_MR1_NOM]; // RULE2
		wt = m2[`DMR_MR2_WTERM]; // RULE17
		// Reserved write termination codes are held as off.
		c.write_termination = (wt >= `DMR_WT_RSV_LO) ? `DMR_TERM_OFF : wt; // RULE19
		c.park_termination = m5[`DMR_MR5_PARK]; // RULE3
		c.output_disable = m1[`DMR_MR1_QOFF]; // RULE8
		c.write_leveling = m1[`DMR_MR1_WLEV]; // RULE7
		c.termination_strobe_function = m1[`DMR_MR1_TERMINATION_STROBE_FUNCTION];
		// The shared pin serves the strobe termination alone when it is on.
		c.write_byte_mask = !m1[`DMR_MR1_TERMINATION_STROBE_FUNCTION] && m5[`DMR_MR5_DM]; // RULE11
		c.write_bus_inversion = !m1[`DMR_MR1_TERMINATION_STROBE_FUNCTION] && m5[`DMR_MR5_WDBI] && !m5[`DMR_MR5_DM]; // RULE12
		c.read_bus_inversion = !m1[`DMR_MR1_TERMINATION_STROBE_FUNCTION] && m5[`DMR_MR5_RDBI]; // RULE11
		c.write_crc = m2[`DMR_MR2_CRC]; // RULE21
		c.self_refresh_range = m2[`DMR_MR2_SRR]; // RULE21
		c.cas_write_delay = dmr_cwl(m2[`DMR_MR2_CWL]); // RULE16
		case (m1[`DMR_MR1_AL])
			`DMR_AL_CL1: c.additive_latency = cl - `DMR_AL_SUB1;
			`DMR_AL_CL2: c.additive_latency = cl - `DMR_AL_SUB2;
			default: c.additive_latency = `DMR_AL_ZERO;
		endcase
		c.total_read_delay = c.additive_latency + cl; // RULE5
		c.total_write_delay = c.additive_latency + 6'(c.cas_write_delay); // RULE6
		return c;
	endfunction

	// A delay of zero is the command itself, otherwise a stage of the line.
	function automatic logic dmr_tap(
		input logic [`DMR_PIPE_DEPTH-1:0] line,
		input logic [5:0] dly,
		input logic now
	);
		logic hit;
		if (dly == `DMR_AL_ZERO) begin
			hit = now;
		end else begin
			hit = line[dly - `DMR_AL_SUB1];
		end
		return hit;
	endfunction

	localparam dmr_pkg::dmr_cfg_s RESET_CFG = dmr_decode('0);

	dmr_pkg::dmr_link_s lnk_reg;
	dmr_pkg::dmr_link_s lnk_next;
	dmr_pkg::dmr_main_s main_reg;
	dmr_pkg::dmr_main_s main_next;
	dmr_pkg::dmr_cfg_s cfg_now;
	logic link_rst_n;
	logic level_s;
	logic ack_s;
	logic req_s;
	logic [2:0] sel;
	logic cmd_mrs;
	logic cmd_rd;
	logic cmd_wr;

	// Reset reaches the link domain through its own synchroniser.
	dmr_sync #(.W(1)) u_link_rst (
		.clk_i(link_clk_i),
		.d_i(reset_n_i),
		.q_o(link_rst_n)
	);

	dmr_sync #(.W(1)) u_level (
		.clk_i(link_clk_i),
		.d_i(level_sample_i),
		.q_o(level_s)
	);

	// The core echoes the request toggle back as its acknowledge.
	dmr_sync #(.W(1)) u_ack (
		.clk_i(link_clk_i),
		.d_i(main_reg.req_seen),
		.q_o(ack_s)
	);

	dmr_sync #(.W(1)) u_req (
		.clk_i(mclk_i),
		.d_i(lnk_reg.req_tgl),
		.q_o(req_s)
	);

	assign cfg_now = dmr_decode(lnk_reg.mr);
	assign sel = {bg_i[0], ba_i};
	assign cmd_mrs = !cs_n_i && act_n_i && !addr_i[`DMR_A_ROW] && !addr_i[`DMR_A_COL]
		&& !addr_i[`DMR_A_WEN];
	// Column commands are taken without regard to the time since activate.
	assign cmd_rd = !cs_n_i && act_n_i && addr_i[`DMR_A_ROW] && !addr_i[`DMR_A_COL]
		&& addr_i[`DMR_A_WEN]; // RULE4
	assign cmd_wr = !cs_n_i && act_n_i && addr_i[`DMR_A_ROW] && !addr_i[`DMR_A_COL]
		&& !addr_i[`DMR_A_WEN]; // RULE4

	always_comb begin
		lnk_next = lnk_reg;
		if (cmd_mrs && sel != `DMR_SEL_IGNORE) begin
			lnk_next.mr[sel] = addr_i; // RULE13
		end
		lnk_next.rd_pipe = {lnk_reg.rd_pipe[`DMR_PIPE_DEPTH-2:0], cmd_rd};
		lnk_next.wr_pipe = {lnk_reg.wr_pipe[`DMR_PIPE_DEPTH-2:0], cmd_wr};
		lnk_next.rd_issue = dmr_tap(lnk_reg.rd_pipe, cfg_now.additive_latency, cmd_rd); // RULE4
		lnk_next.wr_issue = dmr_tap(lnk_reg.wr_pipe, cfg_now.additive_latency, cmd_wr); // RULE4
		lnk_next.rd_due = dmr_tap(lnk_reg.rd_pipe, cfg_now.total_read_delay, cmd_rd); // RULE5
		lnk_next.wr_due = dmr_tap(lnk_reg.wr_pipe, cfg_now.total_write_delay, cmd_wr); // RULE6

		if (lnk_next.wr_due) begin
			lnk_next.wr_win = cfg_now.write_crc ? `DMR_BURST_CRC : `DMR_BURST_BL8; // RULE18
			lnk_next.wr_ten = cfg_now.write_crc; // RULE18
		end else if (lnk_reg.wr_win != `DMR_WIN_IDLE) begin
			lnk_next.wr_win = lnk_reg.wr_win - `DMR_WIN_STEP;
		end
		if (lnk_next.rd_due) begin
			lnk_next.rd_win = `DMR_BURST_BL8;
		end else if (lnk_reg.rd_win != `DMR_WIN_IDLE) begin
			lnk_next.rd_win = lnk_reg.rd_win - `DMR_WIN_STEP;
		end

		// Drivers stay off entirely while outputs are disconnected.
		lnk_next.dq_drive = (lnk_next.rd_win != `DMR_WIN_IDLE || cfg_now.write_leveling)
			&& !cfg_now.output_disable; // RULE8
		lnk_next.lvl_fb = cfg_now.write_leveling && !cfg_now.output_disable && level_s; // RULE7

		if (!termination_control_pin_i) begin
			lnk_next.dq_term = cfg_now.park_termination; // RULE3
		end else if (lnk_next.wr_win != `DMR_WIN_IDLE && !cfg_now.write_leveling
			&& cfg_now.write_termination != `DMR_TERM_OFF) begin
			lnk_next.dq_term = cfg_now.write_termination; // RULE2
		end else begin
			lnk_next.dq_term = cfg_now.nominal_termination; // RULE2
		end
		lnk_next.strobe_term = lnk_next.dq_term; // RULE10
		lnk_next.termination_strobe_function_term = cfg_now.termination_strobe_function ? lnk_next.dq_term
			: `DMR_TERM_OFF; // RULE10

		// A register write landing while a snapshot is taken marks another.
		lnk_next.dirty = lnk_reg.dirty || cmd_mrs;
		case (lnk_reg.hs)
			dmr_pkg::DMR_HS_IDLE: begin
				if (lnk_reg.dirty) begin
					lnk_next.hold = cfg_now;
					lnk_next.req_tgl = !lnk_reg.req_tgl;
					lnk_next.dirty = cmd_mrs;
					lnk_next.hs = dmr_pkg::DMR_HS_BUSY;
				end
			end
			dmr_pkg::DMR_HS_BUSY: begin
				if (ack_s == lnk_reg.req_tgl) begin
					lnk_next.hs = dmr_pkg::DMR_HS_IDLE;
				end
			end
			default: begin
				lnk_next.hs = dmr_pkg::DMR_HS_IDLE;
			end
		endcase

		if (!link_rst_n) begin
			lnk_next = '0;
			lnk_next.mr = {`DMR_MR_COUNT{`DMR_MR_RESET}};
			lnk_next.hold = RESET_CFG;
			lnk_next.dq_term = RESET_CFG.park_termination;
			lnk_next.strobe_term = RESET_CFG.park_termination;
			lnk_next.hs = dmr_pkg::DMR_HS_IDLE;
		end
	end

	always_ff @(posedge link_clk_i) begin
		lnk_reg <= lnk_next;
	end

	// The snapshot is stable from the toggle until the acknowledge returns.
	always_comb begin
		main_next = main_reg;
		if (req_s != main_reg.req_seen) begin
			main_next.cfg = lnk_reg.hold;
			main_next.req_seen = req_s;
		end
		if (!reset_n_i) begin
			main_next.cfg = RESET_CFG;
			main_next.req_seen = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		main_reg <= main_next;
	end

	assign read_issue_o = lnk_reg.rd_issue;
	assign write_issue_o = lnk_reg.wr_issue;
	assign read_data_due_o = lnk_reg.rd_due;
	assign write_data_due_o = lnk_reg.wr_due;
	assign write_burst_ten_o = lnk_reg.wr_ten;
	assign dq_drive_en_o = lnk_reg.dq_drive;
	assign level_feedback_o = lnk_reg.lvl_fb;
	assign dq_termination_o = lnk_reg.dq_term;
	assign strobe_termination_o = lnk_reg.strobe_term;
	assign termination_strobe_function_termination_o = lnk_reg.termination_strobe_function_term;

	assign drive_impedance_o = main_reg.cfg.drive_impedance;
	assign nominal_termination_o = main_reg.cfg.nominal_termination;
	assign write_termination_o = main_reg.cfg.write_termination;
	assign park_termination_o = main_reg.cfg.park_termination;
	assign output_disable_o = main_reg.cfg.output_disable;
	assign write_leveling_o = main_reg.cfg.write_leveling;
	assign termination_strobe_function_o = main_reg.cfg.termination_strobe_function;
	assign write_byte_mask_o = main_reg.cfg.write_byte_mask;
	assign write_bus_inversion_o = main_reg.cfg.write_bus_inversion;
	assign read_bus_inversion_o = main_reg.cfg.read_bus_inversion;
	assign write_crc_o = main_reg.cfg.write_crc;
	assign self_refresh_range_o = main_reg.cfg.self_refresh_range;
	assign cas_write_delay_o = main_reg.cfg.cas_write_delay;
	assign additive_latency_o = main_reg.cfg.additive_latency;
	assign total_read_delay_o = main_reg.cfg.total_read_delay;
	assign total_write_delay_o = main_reg.cfg.total_write_delay;

endmodule // dmr_mode_config

`default_nettype wire

// *** verification/dmr_mode_config_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module dmr_mode_config_chk (
	// Clocks and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic link_clk_i,
	// Link-side outputs
	input wire logic dq_drive_en_o,
	input wire logic read_data_due_o,
	input wire logic write_data_due_o,
	input wire logic write_burst_ten_o,
	input wire logic level_feedback_o,
	input wire logic [2:0] dq_termination_o,
	input wire logic [2:0] strobe_termination_o,
	input wire logic [2:0] termination_strobe_function_termination_o,
	// Core-side settings
	input wire logic output_disable_o,
	input wire logic termination_strobe_function_o,
	input wire logic write_byte_mask_o,
	input wire logic write_bus_inversion_o,
	input wire logic read_bus_inversion_o,
	input wire logic write_crc_o,
	input wire logic [2:0] write_termination_o,
	input wire logic [4:0] cas_write_delay_o,
	input wire logic [5:0] additive_latency_o,
	input wire logic [5:0] total_write_delay_o
);
	a_strobe_same: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		strobe_termination_o == dq_termination_o) else $error("strobe termination differs");
	a_termination_strobe_function_follow: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		termination_strobe_function_termination_o != 3'h0 |-> termination_strobe_function_termination_o == dq_termination_o)
		else $error("termination_strobe_function termination differs");
	a_read_drive: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		read_data_due_o && !output_disable_o |-> dq_drive_en_o) else $error("read window not driven");
	a_drive_len: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		$rose(dq_drive_en_o) |-> dq_drive_en_o [*4]) else $error("drive window too short");
	a_outputs_off: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		output_disable_o |-> !dq_drive_en_o && !level_feedback_o) else $error("output while disabled");
	a_burst_ten: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		write_data_due_o |=> write_burst_ten_o == write_crc_o) else $error("burst length wrong");
	a_write_sum: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		total_write_delay_o == additive_latency_o + {1'b0, cas_write_delay_o})
		else $error("write delay sum wrong");
	a_cwl_code: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cas_write_delay_o inside {5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12})
		else $error("write latency value illegal");
	a_wterm_code: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		write_termination_o < 3'h5) else $error("reserved write termination");
	a_strobe_excl: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		termination_strobe_function_o |-> !(write_byte_mask_o || write_bus_inversion_o
		|| read_bus_inversion_o)) else $error("shared pin function active");
	a_mask_excl: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		!(write_byte_mask_o && write_bus_inversion_o)) else $error("mask and inversion both on");
	c_read: cover property (@(posedge link_clk_i) read_data_due_o);
	c_crc_write: cover property (@(posedge link_clk_i) write_data_due_o && write_crc_o);
	c_strobe: cover property (@(posedge mclk_i) termination_strobe_function_o);
endmodule // dmr_mode_config_chk

bind dmr_mode_config dmr_mode_config_chk dmr_mode_config_chk_i (.mclk_i, .reset_n_i,
	.link_clk_i, .dq_drive_en_o, .read_data_due_o, .write_data_due_o, .write_burst_ten_o,
	.level_feedback_o, .dq_termination_o, .strobe_termination_o, .termination_strobe_function_termination_o,
	.output_disable_o, .termination_strobe_function_o, .write_byte_mask_o,
	.write_bus_inversion_o, .read_bus_inversion_o, .write_crc_o, .write_termination_o,
	.cas_write_delay_o, .additive_latency_o, .total_write_delay_o);

`default_nettype wire

// *** verification/dmr_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module dmr_ctrl_model (
	// Command clock
	input wire logic link_clk_i,
	// Command pins toward the device
	output logic cs_n_o,
	output logic act_n_o,
	output logic [1:0] bg_o,
	output logic [1:0] ba_o,
	output logic [17:0] addr_o
);
	logic go = 1'b0;
	logic [22:0] word = 23'h0;
	initial begin
		cs_n_o = 1'b1;
		{act_n_o, bg_o, ba_o, addr_o} = 23'h0;
	end
	// Deselected lines toggle each cycle so stale values cannot pass for a command.
	always @(negedge link_clk_i) begin
		cs_n_o <= !go;
		if (go) begin
			{act_n_o, bg_o, ba_o, addr_o} <= word;
			go <= 1'b0;
		end else begin
			{act_n_o, bg_o, ba_o, addr_o} <= ~{act_n_o, bg_o, ba_o, addr_o};
		end
	end
	task cmd(input logic [22:0] w);
		word = w;
		go = 1'b1;
		@(negedge link_clk_i);
		@(posedge link_clk_i);
		#1;
	endtask
	// Unused upper address bits and the spare bank group bit go out as zero.
	task ms(input logic [2:0] sel, input logic [17:0] d);
		cmd({1'b1, 1'b0, sel, 4'h0, d[13:0]});
	endtask
endmodule // dmr_ctrl_model

`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %0h seen %0h", n, e, a); end end

module tb;
	logic mclk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic termination_control_pin_i = 1'b0;
	logic level_sample_i = 1'b0;
	logic cs_n_i, act_n_i, read_issue_o, write_issue_o, read_data_due_o, write_data_due_o;
	logic write_burst_ten_o, dq_drive_en_o, level_feedback_o, output_disable_o, write_leveling_o;
	logic termination_strobe_function_o, write_byte_mask_o, write_bus_inversion_o;
	logic read_bus_inversion_o, write_crc_o;
	logic [1:0] bg_i, ba_i, drive_impedance_o, self_refresh_range_o;
	logic [17:0] addr_i;
	logic [2:0] dq_termination_o, strobe_termination_o, termination_strobe_function_termination_o;
	logic [2:0] nominal_termination_o, write_termination_o, park_termination_o, tw;
	logic [4:0] cas_write_delay_o;
	logic [5:0] additive_latency_o, total_read_delay_o, total_write_delay_o;
	logic sawd;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	int ni, nd;
	localparam logic [4:0] CWL_T [7] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12};

	initial forever #4 mclk_i = ~mclk_i;
	initial begin
		#3.3;
		forever #16 link_clk_i = ~link_clk_i;
	end

	dmr_ctrl_model dmr_ctrl_model_i (.link_clk_i(link_clk_i), .cs_n_o(cs_n_i),
		.act_n_o(act_n_i), .bg_o(bg_i), .ba_o(ba_i), .addr_o(addr_i));

	dmr_mode_config dmr_mode_config_i (.mclk_i, .reset_n_i, .link_clk_i, .cs_n_i, .act_n_i,
		.bg_i, .ba_i, .addr_i, .termination_control_pin_i, .level_sample_i, .read_issue_o,
		.write_issue_o, .read_data_due_o, .write_data_due_o, .write_burst_ten_o,
		.dq_drive_en_o, .level_feedback_o, .dq_termination_o, .strobe_termination_o,
		.termination_strobe_function_termination_o, .drive_impedance_o, .nominal_termination_o, .write_termination_o,
		.park_termination_o, .output_disable_o, .write_leveling_o,
		.termination_strobe_function_o, .write_byte_mask_o, .write_bus_inversion_o,
		.read_bus_inversion_o, .write_crc_o, .self_refresh_range_o, .cas_write_delay_o,
		.additive_latency_o, .total_read_delay_o, .total_write_delay_o);

	task give_verdict;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			give_verdict;
		end
	end

	task settle;
		repeat (12) @(posedge link_clk_i);
		#1;
	endtask

	// Sends a read or write and records when issue and due appear, the termination two cycles after due, and any drive.
	task lat(input logic wr);
		ni = 0;
		nd = 0;
		tw = 3'h0;
		sawd = 1'b0;
		dmr_ctrl_model_i.cmd({1'b1, 4'h0, 3'b010, !wr, 14'h0});
		for (int n = 1; n < 60; n++) begin
			@(posedge link_clk_i);
			#1;
			if ((read_issue_o | write_issue_o) && ni == 0) ni = n;
			if ((read_data_due_o | write_data_due_o) && nd == 0) nd = n;
			if (nd != 0 && n == nd + 2) tw = dq_termination_o;
			sawd |= dq_drive_en_o;
		end
	endtask

	initial begin
		repeat (16) @(negedge mclk_i);
		reset_n_i = 1'b1;
		repeat (5) @(posedge link_clk_i);
		#1;
		`CHK("cwl", 5'h09, cas_write_delay_o)
		`CHK("rl", 6'h09, total_read_delay_o)
		$display("test reset done");
		// Only defined field codes are written.
		for (int i = 0; i < 7; i++) begin
			dmr_ctrl_model_i.ms(3'h2, {5'h0, i[0], 3'(i % 5), 1'b0, i[1:0], 3'(i), 3'h0});
			settle;
			`CHK("cwl", CWL_T[i], cas_write_delay_o)
			`CHK("wl", {1'b0, CWL_T[i]}, total_write_delay_o)
			`CHK("wterm", 3'(i % 5), write_termination_o)
			`CHK("srr", i[1:0], self_refresh_range_o)
			`CHK("crc", i[0], write_crc_o)
		end
		$display("test mode two done");
		dmr_ctrl_model_i.ms(3'h0, 18'h00010);
		dmr_ctrl_model_i.ms(3'h1, 18'h0010C);
		dmr_ctrl_model_i.ms(3'h2, 18'h01400);
		dmr_ctrl_model_i.ms(3'h5, 18'h000C0);
		settle;
		`CHK("al", 6'h0A, additive_latency_o)
		`CHK("rl", 6'h15, total_read_delay_o)
		`CHK("wl", 6'h13, total_write_delay_o)
		`CHK("imp", 2'h2, drive_impedance_o)
		`CHK("park", 3'h3, park_termination_o)
		`CHK("dqterm", 3'h3, dq_termination_o)
		`CHK("strobeterm", 3'h3, strobe_termination_o)
		`CHK("nom", 3'h1, nominal_termination_o)
		@(negedge link_clk_i) termination_control_pin_i = 1'b1;
		repeat (2) @(posedge link_clk_i);
		#1;
		`CHK("dqterm", 3'h1, dq_termination_o)
		lat(1'b0);
		`CHK("rd issue", 10, ni)
		`CHK("rd due", 21, nd)
		`CHK("rd drive", 1'b1, sawd)
		dmr_ctrl_model_i.ms(3'h1, 18'h0000C);
		settle;
		lat(1'b1);
		`CHK("wr issue", 10, ni)
		`CHK("wr due", 19, nd)
		`CHK("wr term", 3'h2, tw)
		`CHK("ten", 1'b1, write_burst_ten_o)
		`CHK("dqterm", 3'h0, dq_termination_o)
		$display("test latency done");
		// This controller stands for a by-8 part, the only one allowed the strobe function.
		dmr_ctrl_model_i.ms(3'h1, 18'h00900);
		dmr_ctrl_model_i.ms(3'h5, 18'h01C00);
		settle;
		`CHK("termination_strobe_function", 1'b1, termination_strobe_function_o)
		`CHK("dm", 1'b0, write_byte_mask_o)
		`CHK("wdbi", 1'b0, write_bus_inversion_o)
		`CHK("rdbi", 1'b0, read_bus_inversion_o)
		`CHK("tdqsterm", 3'h1, termination_strobe_function_termination_o)
		dmr_ctrl_model_i.ms(3'h1, 18'h00000);
		settle;
		`CHK("dm", 1'b1, write_byte_mask_o)
		`CHK("wdbi", 1'b0, write_bus_inversion_o)
		`CHK("rdbi", 1'b1, read_bus_inversion_o)
		`CHK("tdqsterm", 3'h0, termination_strobe_function_termination_o)
		$display("test shared pin done");
		dmr_ctrl_model_i.ms(3'h1, 18'h01000);
		settle;
		lat(1'b0);
		`CHK("qoff", 1'b1, output_disable_o)
		`CHK("drive", 1'b0, sawd)
		dmr_ctrl_model_i.ms(3'h1, 18'h00000);
		settle;
		dmr_ctrl_model_i.ms(3'h1, 18'h00080);
		settle;
		@(negedge link_clk_i) level_sample_i = 1'b1;
		settle;
		`CHK("lev", 1'b1, write_leveling_o)
		`CHK("fb", 1'b1, level_feedback_o)
		@(negedge link_clk_i) level_sample_i = 1'b0;
		settle;
		`CHK("fb", 1'b0, level_feedback_o)
		dmr_ctrl_model_i.ms(3'h7, 18'h01000);
		settle;
		`CHK("qoff", 1'b0, output_disable_o)
		`CHK("crc", 1'b1, write_crc_o)
		$display("test output control done");
		give_verdict;
	end
endmodule // tb

`default_nettype wire
